//--- logic/bcp_pkg.sv
// constants, tables and types for the bit configurable i/o port block
// assumes one synchronous clock domain; ports are indexed 0..7 as listed below
//
// Summary of operation
// - software sets each bidirectional bit to input or output individually
// - software enables a per-pin pull-up where the port offers one
// - pull-up acts only while the bit is an input
// - reset puts every direction bit into input, so no pin drives
// - bus-capable pins select a bus threshold input buffer per bit
// - bus-capable pins switch per bit between push-pull and open-drain
// - largest variant: open-drain on bits 0-3, bus buffer on bits 0-1
// - smallest variants: clock/reset port is three input-only bits, pull-up on reset bit
// - mid variant: one bidirectional bit, three input-only, pull-ups on two
// - largest variant: one bidirectional bit and five input-only bits
// - largest variant: remap setting moves second serial channel signals onto alternate pins
// - mid and largest variants: wide peripheral port is eight bits with direction and pull-up
// - largest variant key-input port is six bits with direction and pull-up
package bcp_pkg;

  localparam int PORT_COUNT = 8;
  localparam int PORT_WIDTH = 8;

  // port index map: timer, peripheral, analog, interrupt, rtc, bus, key, clock/reset
  localparam int IDX_TIMER = 0;
  localparam int IDX_WIDE = 1;
  localparam int IDX_ANALOG = 2;
  localparam int IDX_RTC = 4;
  localparam int IDX_BUS = 5;
  localparam int IDX_KEY = 6;
  localparam int IDX_CLKRST = 7;

  // second serial channel pin positions
  localparam int SER_CLK_BIT = 0;
  localparam int SER_DI_BIT = 1;
  localparam int SER_DO_BIT = 2;
  localparam int SER_DO_ALT_BIT = 0;
  localparam int REMAP_BIT = 0;

  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] ANALOG_RESET = 8'hff;

  localparam int VARIANT_SMALL = 0;
  localparam int VARIANT_MID = 1;
  localparam int VARIANT_LARGE = 2;

  localparam logic [7:0] INBUF_MASK = 8'h03;

  typedef enum logic [2:0] {
    BCP_WR_LATCH, BCP_WR_DIR, BCP_WR_PULLUP, BCP_WR_INBUF,
    BCP_WR_DRIVE, BCP_WR_REMAP, BCP_WR_ANALOG
  } bcp_kind_t;

  // bits that exist, index 7 down to 0
  function automatic logic [7:0][7:0] bcp_exist_tab(input int v);
    case (v)
      VARIANT_SMALL: return {8'h26, 8'h00, 8'h03, 8'h00, 8'h01, 8'h0f, 8'h00, 8'h03};
      VARIANT_MID: return {8'h27, 8'h00, 8'h03, 8'h00, 8'h0f, 8'h0f, 8'hff, 8'h03};
      default: return {8'h3f, 8'h3f, 8'h0f, 8'h07, 8'h0f, 8'hff, 8'hff, 8'h07};
    endcase
  endfunction : bcp_exist_tab

  // bits with direction control; the rest are input-only
  function automatic logic [7:0][7:0] bcp_dir_tab(input int v);
    case (v)
      VARIANT_SMALL: return {8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h0f, 8'h00, 8'h03};
      VARIANT_MID: return {8'h01, 8'h00, 8'h03, 8'h00, 8'h0f, 8'h0f, 8'hff, 8'h03};
      default: return {8'h01, 8'h3f, 8'h0f, 8'h07, 8'h0f, 8'hff, 8'hff, 8'h07};
    endcase
  endfunction : bcp_dir_tab

  // bits with a pull-up option
  function automatic logic [7:0][7:0] bcp_pullup_tab(input int v);
    case (v)
      VARIANT_SMALL: return {8'h20, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03};
      VARIANT_MID: return {8'h21, 8'h00, 8'h03, 8'h00, 8'h0f, 8'h00, 8'hff, 8'h03};
      default: return {8'h21, 8'h3f, 8'h0f, 8'h07, 8'h0f, 8'h00, 8'hff, 8'h07};
    endcase
  endfunction : bcp_pullup_tab

  // bus port bits with open-drain option
  function automatic logic [7:0] bcp_od_mask(input int v);
    return (v == VARIANT_LARGE) ? 8'h0f : 8'h03;
  endfunction : bcp_od_mask

endpackage : bcp_pkg

//--- logic/bcp_port.sv
// bit configurable i/o port: latches, direction, pull-up, bus buffer, open-drain, remap
// assumes pins are sampled synchronously to clock; pad drivers and pull-ups sit outside
`timescale 1ns/100ps
`default_nettype none

module bcp_port #(
  parameter int VARIANT = bcp_pkg::VARIANT_LARGE
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [2:0] wr_port,
  input wire bcp_pkg::bcp_kind_t wr_kind,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_port,
  output logic [7:0] rd_data,
  input wire logic [7:0][7:0] pin_in,
  output logic [7:0][7:0] pin_out,
  output logic [7:0][7:0] pin_oe,
  output logic [7:0][7:0] pullup_en,
  output logic [7:0] bus_thresh_sel,
  input wire logic [7:0][7:0] alt_own,
  input wire logic [7:0][7:0] alt_data,
  input wire logic ser_clk_drive,
  input wire logic ser_clk_out,
  input wire logic ser_data_out_en,
  input wire logic ser_data_out,
  output logic ser_clk_in,
  output logic ser_data_in
);

  localparam logic [7:0][7:0] EXIST = bcp_pkg::bcp_exist_tab(VARIANT);
  localparam logic [7:0][7:0] DIR_MASK = bcp_pkg::bcp_dir_tab(VARIANT);
  localparam logic [7:0][7:0] PU_MASK = bcp_pkg::bcp_pullup_tab(VARIANT);
  localparam logic [7:0] OD_MASK = bcp_pkg::bcp_od_mask(VARIANT);
  localparam logic REMAP_AVAIL = (VARIANT == bcp_pkg::VARIANT_LARGE);

  // software-visible state
  logic [7:0][7:0] port_latch_reg, port_latch_next;
  logic [7:0][7:0] port_direction_reg, port_direction_next;
  logic [7:0][7:0] pullup_option_reg, pullup_option_next;
  logic [7:0] input_buffer_select_reg, input_buffer_select_next;
  logic [7:0] output_drive_select_reg, output_drive_select_next;
  logic alternate_function_remap_reg, alternate_function_remap_next;
  logic [7:0] analog_pin_config_reg, analog_pin_config_next;

  // per-bit combinational results
  logic [7:0][7:0] own_eff, src_val, drive_bits, od_bits, read_val;
  logic [7:0][7:0] oe_next, out_next, pu_next;
  logic [7:0] ser_own_bus, ser_val_bus, ser_own_rtc, ser_val_rtc, ser_own_clk, ser_val_clk;
  logic [7:0] rd_next;
  logic ser_clk_in_next, ser_data_in_next;

  // single-register write decodes
  wire wr_inbuf = wr_en && wr_kind == bcp_pkg::BCP_WR_INBUF;
  wire wr_drive = wr_en && wr_kind == bcp_pkg::BCP_WR_DRIVE;
  wire wr_remap = wr_en && wr_kind == bcp_pkg::BCP_WR_REMAP;
  wire wr_analog = wr_en && wr_kind == bcp_pkg::BCP_WR_ANALOG;
  wire remap = alternate_function_remap_reg;

  // bus-buffer and open-drain selects only keep bits that exist on the bus port
  assign input_buffer_select_next = wr_inbuf ? (wr_data & bcp_pkg::INBUF_MASK)
                                             : input_buffer_select_reg;
  assign output_drive_select_next = wr_drive ? (wr_data & OD_MASK)
                                             : output_drive_select_reg;
  assign alternate_function_remap_next = wr_remap ? (wr_data[bcp_pkg::REMAP_BIT] & REMAP_AVAIL)
                                                  : remap;
  assign analog_pin_config_next = wr_analog ? (wr_data & EXIST[bcp_pkg::IDX_ANALOG])
                                            : analog_pin_config_reg;

  // second serial channel: remap chooses between bus port pins and rtc/clock port pins
  assign ser_own_bus = 8'(({7'h00, ser_clk_drive & ~remap} << bcp_pkg::SER_CLK_BIT)
                       | ({7'h00, ser_data_out_en & ~remap} << bcp_pkg::SER_DO_BIT));
  assign ser_val_bus = 8'(({7'h00, ser_clk_out} << bcp_pkg::SER_CLK_BIT)
                       | ({7'h00, ser_data_out} << bcp_pkg::SER_DO_BIT));
  assign ser_own_rtc = 8'({7'h00, ser_clk_drive & remap} << bcp_pkg::SER_CLK_BIT);
  assign ser_val_rtc = 8'({7'h00, ser_clk_out} << bcp_pkg::SER_CLK_BIT);
  assign ser_own_clk = 8'({7'h00, ser_data_out_en & remap} << bcp_pkg::SER_DO_ALT_BIT);
  assign ser_val_clk = 8'({7'h00, ser_data_out} << bcp_pkg::SER_DO_ALT_BIT);
  assign ser_clk_in_next = remap ? pin_in[bcp_pkg::IDX_RTC][bcp_pkg::SER_CLK_BIT]
                                 : pin_in[bcp_pkg::IDX_BUS][bcp_pkg::SER_CLK_BIT];
  assign ser_data_in_next = remap ? pin_in[bcp_pkg::IDX_RTC][bcp_pkg::SER_DI_BIT]
                                  : pin_in[bcp_pkg::IDX_BUS][bcp_pkg::SER_DI_BIT];

  // per-port logic; masks keep absent and input-only bits inert
  for (genvar p = 0; p < bcp_pkg::PORT_COUNT; p++) begin : g_port
    localparam logic [2:0] PIDX = 3'(p);
    wire hit = wr_en && wr_port == PIDX;
    wire [7:0] ser_own = (p == bcp_pkg::IDX_BUS) ? ser_own_bus
                       : (p == bcp_pkg::IDX_RTC) ? ser_own_rtc
                       : (p == bcp_pkg::IDX_CLKRST) ? ser_own_clk : 8'h00;
    wire [7:0] ser_val = (p == bcp_pkg::IDX_BUS) ? ser_val_bus
                       : (p == bcp_pkg::IDX_RTC) ? ser_val_rtc
                       : (p == bcp_pkg::IDX_CLKRST) ? ser_val_clk : 8'h00;
    wire [7:0] od_sel = (p == bcp_pkg::IDX_BUS) ? output_drive_select_reg : 8'h00;
    wire [7:0] ana = (p == bcp_pkg::IDX_ANALOG) ? analog_pin_config_reg : 8'h00;

    // writes always land in the latch, whatever the direction
    assign port_latch_next[p] = (hit && wr_kind == bcp_pkg::BCP_WR_LATCH)
                                ? (wr_data & EXIST[p]) : port_latch_reg[p];
    // 1 = input; bits without direction control stay input for good
    assign port_direction_next[p] = (hit && wr_kind == bcp_pkg::BCP_WR_DIR)
                                    ? (wr_data | ~DIR_MASK[p])
                                    : port_direction_reg[p];
    assign pullup_option_next[p] = (hit && wr_kind == bcp_pkg::BCP_WR_PULLUP)
                                   ? (wr_data & PU_MASK[p])
                                   : pullup_option_reg[p];

    // alternate function overrides the latch, direction still decides drive
    assign own_eff[p] = (alt_own[p] | ser_own) & EXIST[p];
    assign src_val[p] = (own_eff[p] & (alt_data[p] | ser_val))
                        | (~own_eff[p] & port_latch_reg[p]);
    assign drive_bits[p] = ~port_direction_reg[p] & DIR_MASK[p];
    assign od_bits[p] = od_sel & drive_bits[p];
    // open-drain drives only lows; a high floats
    assign oe_next[p] = drive_bits[p] & ~(od_bits[p] & src_val[p]);
    assign out_next[p] = src_val[p] & ~od_bits[p];
    assign pu_next[p] = pullup_option_reg[p] & port_direction_reg[p] & PU_MASK[p];
    // analog-configured input bits read zero so a mid-rail level never reaches software
    assign read_val[p] = ((port_direction_reg[p] & pin_in[p] & ~ana)
                         | (~port_direction_reg[p] & port_latch_reg[p])) & EXIST[p];
  end

  assign rd_next = read_val[rd_port];

  // state registers; reset leaves every pin undriven
  always_ff @(posedge clock) begin
    if (reset) begin
      port_latch_reg <= {bcp_pkg::PORT_COUNT{bcp_pkg::LATCH_RESET}};
      port_direction_reg <= {bcp_pkg::PORT_COUNT{bcp_pkg::DIR_RESET}};
      pullup_option_reg <= {bcp_pkg::PORT_COUNT{bcp_pkg::PULLUP_RESET}};
      input_buffer_select_reg <= bcp_pkg::SEL_RESET;
      output_drive_select_reg <= bcp_pkg::SEL_RESET;
      alternate_function_remap_reg <= 1'b0;
      analog_pin_config_reg <= bcp_pkg::ANALOG_RESET;
    end else begin
      port_latch_reg <= port_latch_next;
      port_direction_reg <= port_direction_next;
      pullup_option_reg <= pullup_option_next;
      input_buffer_select_reg <= input_buffer_select_next;
      output_drive_select_reg <= output_drive_select_next;
      alternate_function_remap_reg <= alternate_function_remap_next;
      analog_pin_config_reg <= analog_pin_config_next;
    end
  end

  // registered outputs, one cycle behind the state they reflect
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe <= '0;
      pullup_en <= '0;
      bus_thresh_sel <= bcp_pkg::SEL_RESET;
      rd_data <= 8'h00;
      ser_clk_in <= 1'b0;
      ser_data_in <= 1'b0;
    end else begin
      pin_out <= out_next;
      pin_oe <= oe_next;
      pullup_en <= pu_next;
      bus_thresh_sel <= input_buffer_select_reg;
      rd_data <= rd_next;
      ser_clk_in <= ser_clk_in_next;
      ser_data_in <= ser_data_in_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_NO_DRIVE_AFTER_RESET: assert property (
    $past(reset) && $past(reset, 2) |-> pin_oe == '0)
    else $error("pin driven right after reset");

  AST_DIR_WRITE: assert property (
    wr_en && wr_kind == bcp_pkg::BCP_WR_DIR |=>
      port_direction_reg[$past(wr_port)] == ($past(wr_data) | ~DIR_MASK[$past(wr_port)]))
    else $error("direction write not taken");

  AST_PULLUP_WRITE: assert property (
    wr_en && wr_kind == bcp_pkg::BCP_WR_PULLUP |=>
      pullup_option_reg[$past(wr_port)] == ($past(wr_data) & PU_MASK[$past(wr_port)]))
    else $error("pull-up write not taken");

  AST_PULLUP_INPUT_ONLY: assert property (
    (pullup_en & pin_oe) == '0)
    else $error("pull-up active on a driven bit");

  AST_OPEN_DRAIN_NO_HIGH: assert property (
    (pin_oe[bcp_pkg::IDX_BUS] & pin_out[bcp_pkg::IDX_BUS]
     & $past(output_drive_select_reg)) == 8'h00)
    else $error("open-drain bit drove high");

  AST_BUS_BUFFER: assert property (
    wr_en && wr_kind == bcp_pkg::BCP_WR_INBUF |=> ##1
      bus_thresh_sel == ($past(wr_data, 2) & bcp_pkg::INBUF_MASK))
    else $error("bus buffer select wrong");

  AST_INPUT_ONLY_BITS: assert property (
    (pin_oe[bcp_pkg::IDX_CLKRST] & ~DIR_MASK[bcp_pkg::IDX_CLKRST]) == 8'h00
    && (pin_oe[bcp_pkg::IDX_KEY] & ~EXIST[bcp_pkg::IDX_KEY]) == 8'h00)
    else $error("input-only or absent bit driven");

  AST_LATCH_READBACK: assert property (
    wr_en && wr_kind == bcp_pkg::BCP_WR_LATCH && rd_port == wr_port
    && (port_direction_reg[wr_port] & EXIST[wr_port]) == 8'h00 ##1
    (!wr_en && $stable(rd_port)) |=>
      rd_data == ($past(wr_data, 2) & EXIST[$past(rd_port)]))
    else $error("output bit read back wrong");

  AST_ALT_OVERRIDE: assert property (
    alt_own[bcp_pkg::IDX_TIMER][0] && !port_direction_reg[bcp_pkg::IDX_TIMER][0] |=>
      pin_oe[bcp_pkg::IDX_TIMER][0] && pin_out[bcp_pkg::IDX_TIMER][0] ==
      $past(alt_data[bcp_pkg::IDX_TIMER][0]))
    else $error("alternate function not routed");

  AST_REMAP_INPUT: assert property (
    alternate_function_remap_reg |=>
      ser_data_in == $past(pin_in[bcp_pkg::IDX_RTC][bcp_pkg::SER_DI_BIT]))
    else $error("remapped serial input not taken");

endmodule : bcp_port

`default_nettype wire

//--- tb/bcp_pin_model.sv
// board-side pin model: resolves each pin level from the port drive and the board
// assumes the bench sets ext_en/ext_val; undriven, unpulled pins toggle each cycle
`timescale 1ns/100ps
`default_nettype none

module bcp_pin_model (
  input wire logic clock,
  input wire logic [7:0][7:0] pin_out,
  input wire logic [7:0][7:0] pin_oe,
  input wire logic [7:0][7:0] pullup_en,
  input wire logic [7:0][7:0] ext_en,
  input wire logic [7:0][7:0] ext_val,
  output logic [7:0][7:0] pin_in
);
  logic flt_reg = 1'b0;

  // a floating pin must not look stable, so it toggles every cycle
  always @(posedge clock) begin
    flt_reg <= ~flt_reg;
  end

  // port drive wins, then the board, then the pull-up
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b]) pin_in[p][b] = pin_out[p][b];
        else if (ext_en[p][b]) pin_in[p][b] = ext_val[p][b];
        else if (pullup_en[p][b]) pin_in[p][b] = 1'b1;
        else pin_in[p][b] = flt_reg;
      end
    end
  end
endmodule : bcp_pin_model

`default_nettype wire

//--- tb/tb_top.sv
// top bench: writes port settings, checks pin drive, pull-ups, reads and remap
// assumes bcp_port as in logic/; small and mid variants share the write inputs
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clock, reset, wr_en, ser_data_out_en, ser_data_out, ser_clk_in, ser_data_in;
  logic ser_clk_drive, ser_clk_out;
  logic [2:0] wr_port, rd_port;
  bcp_pkg::bcp_kind_t wr_kind;
  logic [7:0] wr_data, rd_data, bus_thresh_sel;
  logic [7:0][7:0] pin_in, pin_out, pin_oe, pullup_en, alt_own, alt_data, ext_en, ext_val;
  logic [7:0][7:0] oe_s, pu_s, oe_m, pu_m;
  int n_errors = 0;
  int check_count = 0;

  bcp_port dut_u (.clock, .reset, .wr_en, .wr_port, .wr_kind, .wr_data, .rd_port, .rd_data,
    .pin_in, .pin_out, .pin_oe, .pullup_en, .bus_thresh_sel, .alt_own, .alt_data,
    .ser_clk_drive, .ser_clk_out, .ser_data_out_en, .ser_data_out,
    .ser_clk_in, .ser_data_in);
  bcp_pin_model pins_u (.clock, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);
  // reduced variants only show their direction and pull-up masks
  bcp_port #(.VARIANT(bcp_pkg::VARIANT_SMALL)) dut_s (.clock, .reset, .wr_en, .wr_port,
    .wr_kind, .wr_data, .rd_port, .rd_data(), .pin_in, .pin_out(), .pin_oe(oe_s),
    .pullup_en(pu_s), .bus_thresh_sel(), .alt_own, .alt_data, .ser_clk_drive,
    .ser_clk_out, .ser_data_out_en, .ser_data_out, .ser_clk_in(), .ser_data_in());
  bcp_port #(.VARIANT(bcp_pkg::VARIANT_MID)) dut_m (.clock, .reset, .wr_en, .wr_port,
    .wr_kind, .wr_data, .rd_port, .rd_data(), .pin_in, .pin_out(), .pin_oe(oe_m),
    .pullup_en(pu_m), .bus_thresh_sel(), .alt_own, .alt_data, .ser_clk_drive,
    .ser_clk_out, .ser_data_out_en, .ser_data_out, .ser_clk_in(), .ser_data_in());

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic wr(input bcp_pkg::bcp_kind_t k, input logic [2:0] p, input logic [7:0] d);
    @(posedge clock);
    #1 wr_en = 1'b1;
    wr_kind = k;
    wr_port = p;
    wr_data = d;
    @(posedge clock);
    #1 wr_en = 1'b0;
  endtask : wr

  // two edges: one for the register, one for the registered outputs
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // hang guard: whole sequence needs well under 400 cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    test_done;
  end

  initial begin
    reset = 1'b1;
    wr_en = 1'b0;
    wr_port = 3'h0;
    wr_kind = bcp_pkg::BCP_WR_LATCH;
    wr_data = 8'h00;
    rd_port = 3'h0;
    alt_own = '0;
    alt_data = '0;
    ext_en = '0;
    ext_val = '0;
    ser_data_out_en = 1'b0;
    ser_data_out = 1'b0;
    ser_clk_drive = 1'b0;
    ser_clk_out = 1'b0;
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    for (int p = 0; p < 8; p++) begin
      chk(pin_oe[p], 8'h00);
      chk(pullup_en[p], 8'h00);
    end
    $display("test reset done");
    // single output bit on the timer port
    wr(bcp_pkg::BCP_WR_LATCH, 3'h0, 8'h05);
    wr(bcp_pkg::BCP_WR_DIR, 3'h0, 8'hfe);
    settle;
    chk(pin_oe[0], 8'h01);
    chk({7'h0, pin_out[0][0]}, 8'h01);
    // wide port: split nibbles, read mix, alternate override
    wr(bcp_pkg::BCP_WR_PULLUP, 3'h1, 8'hff);
    wr(bcp_pkg::BCP_WR_LATCH, 3'h1, 8'h3c);
    wr(bcp_pkg::BCP_WR_DIR, 3'h1, 8'hf0);
    ext_en[1] = 8'hf0;
    ext_val[1] = 8'ha5;
    rd_port = 3'h1;
    settle;
    chk(pin_oe[1], 8'h0f);
    chk(pullup_en[1], 8'hf0);
    chk(rd_data, 8'hac);
    alt_own[1] = 8'h11;
    alt_data[1] = 8'h11;
    alt_own[0] = 8'h01;
    alt_data[0] = 8'h00;
    settle;
    chk({4'h0, pin_out[1][3:0]}, 8'h0d);
    chk(pin_oe[1], 8'h0f);
    chk({7'h0, pin_out[0][0]}, 8'h00);
    chk({7'h0, pin_oe[0][0]}, 8'h01);
    $display("test wide port done");
    // key port: six bits, pull-up gone while output
    wr(bcp_pkg::BCP_WR_PULLUP, 3'h6, 8'hff);
    wr(bcp_pkg::BCP_WR_DIR, 3'h6, 8'h00);
    settle;
    chk(pin_oe[6], 8'h3f);
    chk(pullup_en[6], 8'h00);
    // output bits read back from the latch, only existing bits kept
    rd_port = 3'h6;
    wr(bcp_pkg::BCP_WR_LATCH, 3'h6, 8'hea);
    settle;
    chk(rd_data, 8'h2a);
    chk(pin_out[6], 8'h2a);
    wr(bcp_pkg::BCP_WR_DIR, 3'h6, 8'hff);
    settle;
    chk(pullup_en[6], 8'h3f);
    $display("test key port done");
    // clock/reset port across the three variants
    wr(bcp_pkg::BCP_WR_PULLUP, 3'h7, 8'hff);
    settle;
    chk(pullup_en[7], 8'h21);
    chk(pu_m[7], 8'h21);
    chk(pu_s[7], 8'h20);
    wr(bcp_pkg::BCP_WR_DIR, 3'h7, 8'h00);
    settle;
    chk(pin_oe[7], 8'h01);
    chk(oe_m[7], 8'h01);
    chk(oe_s[7], 8'h00);
    chk(pullup_en[7], 8'h20);
    $display("test clock port done");
    // bus port: threshold select and open-drain drive
    wr(bcp_pkg::BCP_WR_INBUF, 3'h0, 8'hff);
    wr(bcp_pkg::BCP_WR_DRIVE, 3'h0, 8'hff);
    wr(bcp_pkg::BCP_WR_LATCH, 3'h5, 8'ha5);
    wr(bcp_pkg::BCP_WR_DIR, 3'h5, 8'h00);
    settle;
    chk(bus_thresh_sel, 8'h03);
    chk({4'h0, pin_out[5][3:0]}, 8'h00);
    chk(pin_oe[5], 8'h0a);
    $display("test bus port done");
    // analog port reads zero until its bits are made digital
    ext_en[2] = 8'hff;
    ext_val[2] = 8'h5a;
    rd_port = 3'h2;
    settle;
    chk(rd_data, 8'h00);
    wr(bcp_pkg::BCP_WR_ANALOG, 3'h0, 8'h0f);
    settle;
    chk(rd_data, 8'h50);
    $display("test analog port done");
    // serial channel moves from bus pins to rtc and clock/reset pins
    ext_en[4] = 8'h03;
    ext_val[4] = 8'h03;
    ser_clk_drive = 1'b1;
    settle;
    chk({7'h0, ser_data_in}, 8'h00);
    chk(pin_oe[5], 8'h0b);
    chk({7'h0, ser_clk_in}, 8'h00);
    wr(bcp_pkg::BCP_WR_REMAP, 3'h0, 8'h01);
    ser_clk_out = 1'b1;
    ser_data_out_en = 1'b1;
    ser_data_out = 1'b1;
    settle;
    chk({7'h0, ser_data_in}, 8'h01);
    chk({7'h0, pin_out[7][0]}, 8'h01);
    chk({7'h0, ser_clk_in}, 8'h01);
    chk({7'h0, pin_out[4][0]}, 8'h01);
    chk(pin_oe[5], 8'h0a);
    $display("test remap done");
    // second reset in mid-run releases every pin
    @(posedge clock);
    #1 reset = 1'b1;
    settle;
    reset = 1'b0;
    chk(pin_oe[7], 8'h00);
    chk(pin_oe[1], 8'h00);
    $display("test second reset done");
    test_done;
  end
endmodule : tb_top

`default_nettype wire
